// ==== link_latency_meter.sv ====
// Purpose: Local receive LMFC for one link and measured latency to first data.
// Assumes: Frame and processing clock ticks are enables on sys_clk.
// Notes: Latency counts processing clock cycles from the local LMFC edge.
`timescale 1ns/1ps
`include "lmfc_align_map.svh"
module link_latency_meter #(
  parameter int FW = `FRAME_CNT_W,
  parameter int PW = `PCLK_CNT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic frame_tick,
  input wire logic pclk_tick,
  input wire logic lmfc_edge,
  input wire logic [FW-1:0] frames_per_mf_m1,
  input wire logic [7:0] lmfc_delay,
  input wire logic ilas_to_data,
  output logic local_lmfc,
  output logic [PW-1:0] latency
);
  initial begin
    if (FW < 1 || PW < 4) $error("link_latency_meter widths too small");
  end

  logic [FW-1:0] dcnt_reg;
  logic arm_reg;
  logic loc_reg;
  logic [PW-1:0] pcnt_reg;
  logic [PW-1:0] lat_reg;
  wire [FW-1:0] del_mod = lmfc_delay[FW-1:0] & frames_per_mf_m1;
  // The count is zero at the edge, so the last frame of the delay is reached at delay minus one.
  wire [FW-1:0] del_m1 = del_mod - 1'b1;
  wire delay_done = arm_reg && frame_tick && (dcnt_reg == del_m1);
  wire loc_fire = (lmfc_edge && del_mod == '0) || delay_done;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dcnt_reg <= '0;
      arm_reg <= 1'b0;
      loc_reg <= 1'b0;
      pcnt_reg <= '0;
      lat_reg <= '0;
    end else begin
      loc_reg <= loc_fire;
      if (lmfc_edge && del_mod != '0) begin
        arm_reg <= 1'b1;
        dcnt_reg <= '0;
      end else if (delay_done) begin
        arm_reg <= 1'b0;
      end else if (arm_reg && frame_tick) begin
        dcnt_reg <= dcnt_reg + 1'b1;
      end
      if (loc_fire) begin
        pcnt_reg <= '0;
      end else if (pclk_tick) begin
        pcnt_reg <= pcnt_reg + 1'b1;
      end
      if (ilas_to_data) begin
        lat_reg <= pcnt_reg;
      end
    end
  end

  assign local_lmfc = loc_reg;
  assign latency = lat_reg;
endmodule

// ==== lmfc_align_map.svh ====
// Purpose: Register offsets, field positions, reset values and counts of the LMFC alignment block.
// Assumes: Byte-wide registers on a 12-bit register address.
// Notes: Definitions only.
`ifndef LMFC_ALIGN_MAP_SVH
`define LMFC_ALIGN_MAP_SVH

// ==========================================================================
// Register offsets
`define ADDR_IRQ_EN_A 12'h0021
`define ADDR_IRQ_EN_B 12'h0022
`define ADDR_IRQ_ST_A 12'h0025
`define ADDR_IRQ_ST_B 12'h0026
`define ADDR_SUBCLASS 12'h0301
`define ADDR_LAT0 12'h0302
`define ADDR_LAT1 12'h0303
`define ADDR_LDEL_A 12'h0304
`define ADDR_LDEL_B 12'h0305
`define ADDR_VAR_A 12'h0306
`define ADDR_VAR_B 12'h0307
`define ADDR_LINK_CFG 12'h0458

// ==========================================================================
// Field positions
`define EV_LOCK 0
`define EV_ROT 1
`define EV_TRIP 2
`define EV_WLIM 3
`define EV_MSB 3
`define SUBCLASS_MSB 2
`define LINK_SC_LSB 5
`define LINK_SC_MSB 7

// ==========================================================================
// Values and counts
`define RST_BYTE 8'h00
`define SUBCLASS_0 3'h0
`define SUBCLASS_1 3'h1
`define RBD_MAX 8'h0a
`define PCLK_FRAME_NUM 4'h4
`define FRAME_CNT_W 5
`define PCLK_CNT_W 8

`endif

// ==== lmfc_align_monitor.sv ====
// Purpose: Port checker for the LMFC alignment block.
// Assumes: Settings are tracked by snooping register writes.
// Notes: Bound to the block at the foot of this file.
`timescale 1ns/1ps
`include "lmfc_align_map.svh"
module lmfc_align_monitor #(
  parameter int N_LANES = 4,
  parameter int PW = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sysref_edge,
  input wire logic internal_align_edge,
  input wire logic [1:0] octets_per_frame_code,
  input wire logic [1:0] phase_check,
  input wire logic [1:0] phase_aligned,
  input wire logic [2*N_LANES-1:0] lane_arrived,
  input wire logic [1:0] link_error,
  input wire logic [1:0] link_sync_request_output,
  input wire logic [1:0] lane_read_enable,
  input wire logic [1:0] local_lmfc,
  input wire logic irq
);
  // ==========================================================================
  // Settings shadow
  logic [2:0] sc_reg;
  logic [3:0] en_a_reg;
  logic [3:0] en_b_reg;
  logic [7:0] ldel_reg;
  wire logic sc0 = (sc_reg == `SUBCLASS_0);
  wire logic mask_on = sc0 && (octets_per_frame_code == 2'h0);
  wire logic edge_sel = sc0 ? internal_align_edge : sysref_edge;
  wire logic lanes0 = &lane_arrived[N_LANES-1:0];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sc_reg <= 3'h0;
      en_a_reg <= 4'h0;
      en_b_reg <= 4'h0;
      ldel_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_SUBCLASS && reg_wdata[2:1] == 2'h0) sc_reg <= reg_wdata[2:0];
      if (reg_addr == `ADDR_IRQ_EN_A) en_a_reg <= reg_wdata[3:0];
      if (reg_addr == `ADDR_IRQ_EN_B) en_b_reg <= reg_wdata[3:0];
      if (reg_addr == `ADDR_LDEL_A) ldel_reg <= reg_wdata;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    irq == 1'b0 && local_lmfc == 2'h0 && lane_read_enable == 2'h0 && link_sync_request_output == 2'h0)
    else $error("outputs not cleared by reset");
  a_sync_masked: assert property (mask_on |=> link_sync_request_output == 2'h0)
    else $error("sync output not masked");
  a_sync_follow: assert property (!mask_on |=> link_sync_request_output == $past(link_error))
    else $error("sync output does not follow errors");
  a_irq_rise: assert property (phase_check[0] && phase_aligned[0] && en_a_reg[`EV_LOCK] |-> ##2 irq)
    else $error("irq late after enabled lock event");
  a_irq_quiet: assert property ((en_a_reg == 4'h0 && en_b_reg == 4'h0) [*3] |-> !irq)
    else $error("irq with no event enabled");
  a_lmfc_edge: assert property (edge_sel && ldel_reg == 8'h00 |=> local_lmfc[0])
    else $error("local lmfc missing after edge");
  a_read_needs_lanes: assert property ($rose(lane_read_enable[0]) |-> $past(lanes0))
    else $error("read opened before lanes arrived");
  a_read_drop: assert property (lane_read_enable[0] && !lanes0 |=> !lane_read_enable[0])
    else $error("read kept open after lane drop");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  c_irq_seen: cover property ($rose(irq));
  c_read_open: cover property ($rose(lane_read_enable[0]));
  c_lmfc_b: cover property (local_lmfc[1]);
endmodule
bind lmfc_latency_align lmfc_align_monitor #(.N_LANES(N_LANES), .PW(PW)) lmfc_align_monitor_inst (.sys_clk, .reset,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sysref_edge, .internal_align_edge, .octets_per_frame_code,
  .phase_check, .phase_aligned, .lane_arrived, .link_error, .link_sync_request_output, .lane_read_enable,
  .local_lmfc, .irq);

// ==== lmfc_align_pkg.sv ====
// Purpose: Types shared by the LMFC alignment block.
// Assumes: Nothing beyond the map header.
// Notes: Holds types only.
package lmfc_align_pkg;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_ILAS = 3'b010,
    LS_DATA = 3'b100
  } link_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// ==== lmfc_latency_align.sv ====
// Purpose: Receive-side deterministic latency alignment and sync event reporting.
// Assumes: Byte register port; frame and processing clock ticks arrive as enables.
// Notes: Two links; link 0 pairs with converter pair A, link 1 with pair B.
// Contract
// - Four sync conditions each separately enableable events.
// - Pair A enables and status registers.
// - Pair B enables and status registers.
// - Subclass 0 and 1 supported, not 2.
// - Subclass 0 ignores alignment pulse input.
// - Lanes within one LMFC; pairs synchronised.
// - No sync error report in Subclass 0, F=1.
// - Subclass 1 aligns to half converter clock.
// - All lanes read in same LMFC period.
// - Local LMFC delayed by programmed frame count.
// - Buffer delay accepts zero to ten cycles.
// - Variation value used as buffer delay.
// - Frame per processing clock ratio is 4/F.
// - Per-link measured latency readback registers.
// - Trip set after edge received and checked.
// - Lock set when aligned, updated every check; the code only sets it on an aligned check and holds it until a write-one clear.
`timescale 1ns/1ps
`include "lmfc_align_map.svh"
module lmfc_latency_align #(
  parameter int N_LANES = 4,
  parameter int PW = `PCLK_CNT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  // Byte register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Timing enables and alignment edge.
  input wire logic frame_tick,
  input wire logic pclk_tick,
  input wire logic sysref_edge,
  input wire logic internal_align_edge,
  input wire logic [1:0] octets_per_frame_code,
  input wire logic [4:0] frames_per_mf_m1,
  // Phase check results from the sync machine, one pair per link.
  input wire logic [1:0] phase_check,
  input wire logic [1:0] phase_aligned,
  input wire logic [1:0] rotation_done,
  input wire logic [1:0] window_exceeded,
  // Per-link lane status.
  input wire logic [1:0] ilas_to_data,
  input wire logic [2*N_LANES-1:0] lane_arrived,
  input wire logic [1:0] link_error,
  output logic [1:0] link_sync_request_output,
  output logic [1:0] lane_read_enable,
  output logic [1:0] local_lmfc,
  output logic irq
);
  initial begin
    if (N_LANES < 1 || N_LANES > 8) $error("lmfc_latency_align lane count out of range");
    if (PW < 4) $error("lmfc_latency_align latency width too small");
  end

  // ==========================================================================
  // Register storage
  logic [`EV_MSB:0] en_a_reg;
  logic [`EV_MSB:0] en_b_reg;
  logic [`SUBCLASS_MSB:0] subclass_reg;
  logic [`LINK_SC_MSB-`LINK_SC_LSB:0] link_sc_reg;
  logic [`LINK_SC_LSB-1:0] link_cfg_low_reg;
  lmfc_align_pkg::reg_byte_t ldel_a_reg;
  lmfc_align_pkg::reg_byte_t ldel_b_reg;
  lmfc_align_pkg::reg_byte_t var_a_reg;
  lmfc_align_pkg::reg_byte_t var_b_reg;
  lmfc_align_pkg::reg_byte_t rdata_reg;
  logic irq_reg;
  logic [1:0] sync_out_reg;

  wire wr_en_a = reg_wr && reg_addr == `ADDR_IRQ_EN_A;
  wire wr_en_b = reg_wr && reg_addr == `ADDR_IRQ_EN_B;
  wire wr_st_a = reg_wr && reg_addr == `ADDR_IRQ_ST_A;
  wire wr_st_b = reg_wr && reg_addr == `ADDR_IRQ_ST_B;
  wire wr_sc = reg_wr && reg_addr == `ADDR_SUBCLASS;
  wire wr_ldel_a = reg_wr && reg_addr == `ADDR_LDEL_A;
  wire wr_ldel_b = reg_wr && reg_addr == `ADDR_LDEL_B;
  wire wr_var_a = reg_wr && reg_addr == `ADDR_VAR_A;
  wire wr_var_b = reg_wr && reg_addr == `ADDR_VAR_B;
  wire wr_link = reg_wr && reg_addr == `ADDR_LINK_CFG;

  // Subclass 2 and other codes are refused; the field keeps its old value.
  wire sc_ok = reg_wdata[`SUBCLASS_MSB:0] == `SUBCLASS_0 || reg_wdata[`SUBCLASS_MSB:0] == `SUBCLASS_1;
  wire link_sc_ok = reg_wdata[`LINK_SC_MSB:`LINK_SC_LSB] == `SUBCLASS_0 ||
                    reg_wdata[`LINK_SC_MSB:`LINK_SC_LSB] == `SUBCLASS_1;
  // Buffer delay values above ten are clamped.
  wire [7:0] var_wdata = reg_wdata > `RBD_MAX ? `RBD_MAX : reg_wdata;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_a_reg <= '0;
      en_b_reg <= '0;
      subclass_reg <= `SUBCLASS_0;
      link_sc_reg <= `SUBCLASS_0;
      link_cfg_low_reg <= '0;
      ldel_a_reg <= `RST_BYTE;
      ldel_b_reg <= `RST_BYTE;
      var_a_reg <= `RST_BYTE;
      var_b_reg <= `RST_BYTE;
    end else begin
      // Status registers are write-one-to-clear inside the event latches.
      if (wr_en_a) begin
        en_a_reg <= reg_wdata[`EV_MSB:0];
      end
      if (wr_en_b) begin
        en_b_reg <= reg_wdata[`EV_MSB:0];
      end
      if (wr_sc && sc_ok) begin
        subclass_reg <= reg_wdata[`SUBCLASS_MSB:0];
      end
      if (wr_link) begin
        link_cfg_low_reg <= reg_wdata[`LINK_SC_LSB-1:0];
      end
      if (wr_link && link_sc_ok) begin
        link_sc_reg <= reg_wdata[`LINK_SC_MSB:`LINK_SC_LSB];
      end
      if (wr_ldel_a) begin
        ldel_a_reg <= reg_wdata;
      end
      if (wr_ldel_b) begin
        ldel_b_reg <= reg_wdata;
      end
      if (wr_var_a) begin
        var_a_reg <= var_wdata;
      end
      if (wr_var_b) begin
        var_b_reg <= var_wdata;
      end
    end
  end

  // ==========================================================================
  // Subclass and alignment edge
  wire sub1 = subclass_reg == `SUBCLASS_1;
  // Subclass 0 never looks at the external alignment pulse.
  wire align_edge = sub1 ? sysref_edge : internal_align_edge;
  // One shared LMFC keeps both pairs on the same multiframe.
  logic [4:0] mf_cnt_reg;
  wire mf_wrap = frame_tick && mf_cnt_reg == frames_per_mf_m1;
  wire lmfc_edge = align_edge || mf_wrap;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mf_cnt_reg <= '0;
    end else if (align_edge) begin
      mf_cnt_reg <= '0;
    end else if (frame_tick) begin
      mf_cnt_reg <= mf_wrap ? 5'h00 : mf_cnt_reg + 5'h01;
    end
  end

  // Frames per processing clock is four divided by octets per frame.
  wire [3:0] f_octets = octets_per_frame_code == 2'h0 ? 4'h1 :
                        octets_per_frame_code == 2'h1 ? 4'h2 : 4'h4;
  wire [3:0] frames_per_parallel_processing_clock_ratio = `PCLK_FRAME_NUM / f_octets;
  wire f_is_one = f_octets == 4'h1;

  // ==========================================================================
  // Per-link local LMFC, latency, buffer release
  wire [7:0] link_delay [2];
  wire [7:0] link_var [2];
  wire [PW-1:0] link_lat [2];
  assign link_delay[0] = ldel_a_reg;
  assign link_delay[1] = ldel_b_reg;
  assign link_var[0] = var_a_reg;
  assign link_var[1] = var_b_reg;

  lmfc_align_pkg::link_state_e st_reg [2];
  logic [7:0] rbd_cnt_reg [2];
  logic [1:0] read_reg;
  wire [1:0] loc_lmfc;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_link
      link_latency_meter #(
        .FW(`FRAME_CNT_W),
        .PW(PW)
      ) u_meter (
        .sys_clk(sys_clk),
        .reset(reset),
        .frame_tick(frame_tick),
        .pclk_tick(pclk_tick),
        .lmfc_edge(lmfc_edge),
        .frames_per_mf_m1(frames_per_mf_m1),
        .lmfc_delay(link_delay[g]),
        .ilas_to_data(ilas_to_data[g]),
        .local_lmfc(loc_lmfc[g]),
        .latency(link_lat[g])
      );

      wire all_in = &lane_arrived[g*N_LANES +: N_LANES];
      // Reading starts the buffer delay after the local LMFC, for all lanes at once.
      wire rbd_done = rbd_cnt_reg[g] == link_var[g];
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          st_reg[g] <= lmfc_align_pkg::LS_IDLE;
          rbd_cnt_reg[g] <= `RST_BYTE;
          read_reg[g] <= 1'b0;
        end else begin
          case (st_reg[g])
            lmfc_align_pkg::LS_IDLE: begin
              read_reg[g] <= 1'b0;
              if (loc_lmfc[g] && all_in) begin
                st_reg[g] <= lmfc_align_pkg::LS_ILAS;
                rbd_cnt_reg[g] <= `RST_BYTE;
              end
            end
            lmfc_align_pkg::LS_ILAS: begin
              // A lane lost while waiting restarts alignment at the next local LMFC.
              if (!all_in) begin
                st_reg[g] <= lmfc_align_pkg::LS_IDLE;
              end else if (rbd_done) begin
                st_reg[g] <= lmfc_align_pkg::LS_DATA;
                read_reg[g] <= 1'b1;
              end else if (pclk_tick) begin
                rbd_cnt_reg[g] <= rbd_cnt_reg[g] + 8'h01;
              end
            end
            lmfc_align_pkg::LS_DATA: begin
              if (!all_in) begin
                st_reg[g] <= lmfc_align_pkg::LS_IDLE;
                read_reg[g] <= 1'b0;
              end
            end
            default: begin
              st_reg[g] <= lmfc_align_pkg::LS_IDLE;
              read_reg[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // Errors are not signalled in Subclass 0 with one octet per frame.
  wire err_mask = !sub1 && f_is_one;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_out_reg <= 2'b00;
    end else begin
      sync_out_reg <= err_mask ? 2'b00 : link_error;
    end
  end

  // ==========================================================================
  // Sync events
  wire [`EV_MSB:0] ev [2];
  wire [`EV_MSB:0] st [2];
  wire [1:0] pend;
  generate
    for (g = 0; g < 2; g++) begin : g_ev
      assign ev[g][`EV_LOCK] = phase_check[g] && phase_aligned[g];
      assign ev[g][`EV_ROT] = rotation_done[g];
      assign ev[g][`EV_TRIP] = phase_check[g] && align_edge;
      assign ev[g][`EV_WLIM] = phase_check[g] && window_exceeded[g];
    end
  endgenerate

  sync_event_latch #(.N_EV(`EV_MSB + 1)) u_ev_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .event_pulse(ev[0]),
    .enable(en_a_reg),
    .clear_wr(wr_st_a),
    .clear_bits(reg_wdata[`EV_MSB:0]),
    .status(st[0]),
    .pending(pend[0])
  );

  sync_event_latch #(.N_EV(`EV_MSB + 1)) u_ev_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .event_pulse(ev[1]),
    .enable(en_b_reg),
    .clear_wr(wr_st_b),
    .clear_bits(reg_wdata[`EV_MSB:0]),
    .status(st[1]),
    .pending(pend[1])
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |pend;
    end
  end

  // ==========================================================================
  // Read data
  wire [7:0] lat0_b = 8'(link_lat[0]);
  wire [7:0] lat1_b = 8'(link_lat[1]);
  wire [7:0] rd_mux =
    reg_addr == `ADDR_IRQ_EN_A ? {4'h0, en_a_reg} :
    reg_addr == `ADDR_IRQ_EN_B ? {4'h0, en_b_reg} :
    reg_addr == `ADDR_IRQ_ST_A ? {4'h0, st[0]} :
    reg_addr == `ADDR_IRQ_ST_B ? {4'h0, st[1]} :
    reg_addr == `ADDR_SUBCLASS ? {5'h00, subclass_reg} :
    reg_addr == `ADDR_LAT0 ? lat0_b :
    reg_addr == `ADDR_LAT1 ? lat1_b :
    reg_addr == `ADDR_LDEL_A ? ldel_a_reg :
    reg_addr == `ADDR_LDEL_B ? ldel_b_reg :
    reg_addr == `ADDR_VAR_A ? var_a_reg :
    reg_addr == `ADDR_VAR_B ? var_b_reg :
    reg_addr == `ADDR_LINK_CFG ? {link_sc_reg, link_cfg_low_reg} :
    reg_addr == `ADDR_LINK_CFG + 12'h0001 ? {4'h0, frames_per_parallel_processing_clock_ratio} : `RST_BYTE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_reg <= `RST_BYTE;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign link_sync_request_output = sync_out_reg;
  assign lane_read_enable = read_reg;
  assign local_lmfc = loc_lmfc;
endmodule

// ==== sync_event_latch.sv ====
// Purpose: Sticky sync events with enables for one converter pair.
// Assumes: Events are single-cycle pulses; write-one-to-clear status.
// Notes: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`include "lmfc_align_map.svh"
module sync_event_latch #(
  parameter int N_EV = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [N_EV-1:0] event_pulse,
  input wire logic [N_EV-1:0] enable,
  input wire logic clear_wr,
  input wire logic [N_EV-1:0] clear_bits,
  output logic [N_EV-1:0] status,
  output logic pending
);
  initial begin
    if (N_EV != `EV_MSB + 1) $error("sync_event_latch needs four events");
  end

  logic [N_EV-1:0] status_reg;
  wire [N_EV-1:0] clr_mask = clear_wr ? clear_bits : '0;
  wire [N_EV-1:0] set_mask = event_pulse & enable;
  wire [N_EV-1:0] status_next = (status_reg & ~clr_mask) | set_mask;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;
  assign pending = |(status_reg & enable);
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the LMFC alignment block.
// Assumes: Inputs change at the falling edge.
// Notes: Frame and processing ticks are given one by one.
`timescale 1ns/1ps
`include "lmfc_align_map.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic frame_tick = 1'b0, pclk_tick = 1'b0, sysref_edge = 1'b0, internal_align_edge = 1'b0;
  logic [1:0] octets_per_frame_code = 2'h0;
  logic [4:0] frames_per_mf_m1 = 5'h1f;
  logic [1:0] phase_check = 2'h0, phase_aligned = 2'h0, rotation_done = 2'h0, window_exceeded = 2'h0;
  logic [1:0] link_up = 2'h0, send_ilas = 2'h0, link_error = 2'h0, lmfc_seen = 2'h0;
  logic seen_clr = 1'b0;
  logic [1:0] ilas_to_data, link_sync_request_output, lane_read_enable, local_lmfc;
  logic [7:0] reg_rdata, lane_arrived;
  logic irq;
  int failures = 0, checks = 0;
  lmfc_latency_align #(.N_LANES(4)) lmfc_latency_align_inst (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .frame_tick, .pclk_tick, .sysref_edge, .internal_align_edge, .octets_per_frame_code,
    .frames_per_mf_m1, .phase_check, .phase_aligned, .rotation_done, .window_exceeded, .ilas_to_data,
    .lane_arrived, .link_error, .link_sync_request_output, .lane_read_enable, .local_lmfc, .irq);
  tx_link_model #(.N_LANES(4)) tx_link_model_inst (.sys_clk, .reset, .link_up, .send_ilas, .lane_arrived,
    .ilas_to_data);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) lmfc_seen <= seen_clr ? 2'h0 : (lmfc_seen | local_lmfc);
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    check(reg_rdata, exp);
  endtask
  task automatic fire(input int l, input int i);
    phase_check[l] = (i != 1);
    phase_aligned[l] = (i == 0);
    rotation_done[l] = (i == 1);
    internal_align_edge = (i == 2);
    window_exceeded[l] = (i == 3);
    step(1);
    phase_check = 2'h0;
    phase_aligned = 2'h0;
    rotation_done = 2'h0;
    internal_align_edge = 1'b0;
    window_exceeded = 2'h0;
    step(1);
  endtask
  task automatic edge_in(input logic ext);
    seen_clr = 1'b1;
    sysref_edge = ext;
    internal_align_edge = !ext;
    step(1);
    seen_clr = 1'b0;
    sysref_edge = 1'b0;
    internal_align_edge = 1'b0;
    step(3);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      frame_tick = 1'b1;
      step(1);
      frame_tick = 1'b0;
      step(2);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rchk(`ADDR_IRQ_EN_A, 8'h00);
    wr(`ADDR_IRQ_EN_B, 8'h0f);
    rchk(`ADDR_IRQ_EN_B, 8'h0f);
    wr(`ADDR_SUBCLASS, 8'h02);
    rchk(`ADDR_SUBCLASS, 8'h00);
    wr(`ADDR_SUBCLASS, 8'h01);
    rchk(`ADDR_SUBCLASS, 8'h01);
    wr(`ADDR_LINK_CFG, 8'h20);
    rchk(`ADDR_LINK_CFG, 8'h20);
    wr(`ADDR_VAR_A, 8'h0b);
    rchk(`ADDR_VAR_A, `RBD_MAX);
    wr(`ADDR_LDEL_B, 8'h1a);
    rchk(`ADDR_LDEL_B, 8'h1a);
    wr(`ADDR_LAT0, 8'h55);
    rchk(`ADDR_LAT0, 8'h00);
    rchk(12'h0100, 8'h00);
    for (int f = 0; f < 3; f++) begin
      octets_per_frame_code = f[1:0];
      rchk(12'h0459, 8'h04 >> f);
    end
    wr(`ADDR_SUBCLASS, 8'h00);
    wr(`ADDR_IRQ_EN_B, 8'h00);
    wr(`ADDR_LDEL_B, 8'h00);
  endtask
  task automatic t_events;
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_IRQ_EN_A, 8'h01 << i);
      fire(0, i);
      step(1);
      check({7'h00, irq}, 8'h01);
      rchk(`ADDR_IRQ_ST_A, 8'h01 << i);
      wr(`ADDR_IRQ_ST_A, 8'h01 << i);
      step(2);
      check({7'h00, irq}, 8'h00);
      rchk(`ADDR_IRQ_ST_A, 8'h00);
    end
    wr(`ADDR_IRQ_EN_A, 8'h00);
    fire(0, 0);
    rchk(`ADDR_IRQ_ST_A, 8'h00);
    wr(`ADDR_IRQ_EN_B, 8'h02);
    fire(1, 1);
    rchk(`ADDR_IRQ_ST_B, 8'h02);
    check({7'h00, irq}, 8'h01);
    wr(`ADDR_IRQ_ST_B, 8'h02);
    rchk(`ADDR_IRQ_ST_B, 8'h00);
    wr(`ADDR_IRQ_EN_B, 8'h00);
  endtask
  task automatic t_sync;
    link_error = 2'h3;
    octets_per_frame_code = 2'h0;
    step(3);
    check({6'h00, link_sync_request_output}, 8'h00);
    octets_per_frame_code = 2'h1;
    step(3);
    check({6'h00, link_sync_request_output}, 8'h03);
    octets_per_frame_code = 2'h0;
    wr(`ADDR_SUBCLASS, 8'h01);
    step(2);
    check({6'h00, link_sync_request_output}, 8'h03);
    wr(`ADDR_SUBCLASS, 8'h00);
    link_error = 2'h0;
  endtask
  task automatic t_lmfc;
    edge_in(1'b1);
    check({6'h00, lmfc_seen}, 8'h00);
    edge_in(1'b0);
    check({6'h00, lmfc_seen}, 8'h03);
    check({6'h00, local_lmfc}, 8'h00);
    frames_per_mf_m1 = 5'h0f;
    wr(`ADDR_LDEL_A, 8'h12);
    wr(`ADDR_LDEL_B, 8'h12);
    edge_in(1'b0);
    frames(1);
    check({6'h00, lmfc_seen}, 8'h00);
    frames(1);
    check({6'h00, lmfc_seen}, 8'h03);
    frames_per_mf_m1 = 5'h1f;
    wr(`ADDR_LDEL_A, 8'h00);
    wr(`ADDR_LDEL_B, 8'h00);
    wr(`ADDR_SUBCLASS, 8'h01);
    edge_in(1'b1);
    check({6'h00, lmfc_seen}, 8'h03);
    wr(`ADDR_SUBCLASS, 8'h00);
  endtask
  task automatic t_latency;
    logic [7:0] lo, hi, dv, dl;
    wr(`ADDR_VAR_A, 8'h03);
    wr(`ADDR_VAR_B, 8'h03);
    link_up = 2'h3;
    step(8);
    edge_in(1'b0);
    for (int t = 1; t <= 5; t++) begin
      pclk_tick = 1'b1;
      step(1);
      pclk_tick = 1'b0;
      step(2);
      check({6'h00, lane_read_enable}, (t >= 3) ? 8'h03 : 8'h00);
    end
    send_ilas = 2'h3;
    step(1);
    send_ilas = 2'h0;
    step(3);
    rchk(`ADDR_LAT0, 8'h05);
    rchk(`ADDR_LAT1, 8'h05);
    link_up = 2'h1;
    step(3);
    check({6'h00, lane_read_enable}, 8'h01);
    link_up = 2'h0;
    step(3);
    check({6'h00, lane_read_enable}, 8'h00);
    // Software setup: a second reading past the multiframe edge is unwrapped by one multiframe.
    lo = 8'h05;
    hi = 8'h01 + 8'h08;
    dv = (hi + 8'h01) - (lo - 8'h01);
    dl = ((lo - 8'h01) * 8'h04) % 8'h20;
    wr(`ADDR_VAR_A, dv);
    wr(`ADDR_VAR_B, dv);
    wr(`ADDR_LDEL_A, dl);
    wr(`ADDR_LDEL_B, dl);
    rchk(`ADDR_VAR_B, 8'h06);
    rchk(`ADDR_LDEL_A, 8'h10);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    step(10);
    reset = 1'b0;
    t_regs();
    t_events();
    t_sync();
    t_lmfc();
    t_latency();
    stop_test();
  end
endmodule

// ==== tx_link_model.sv ====
// Purpose: Transmitter side of the two links, lane arrival and alignment sequence end.
// Assumes: Commands come from the bench.
// Notes: Outputs change just after the rising edge.
`timescale 1ns/1ps
module tx_link_model #(
  parameter int N_LANES = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] link_up,
  input wire logic [1:0] send_ilas,
  output logic [2*N_LANES-1:0] lane_arrived,
  output logic [1:0] ilas_to_data
);
  always @(posedge sys_clk) begin
    if (reset) begin
      lane_arrived <= '0;
      ilas_to_data <= 2'h0;
    end else begin
      for (int l = 0; l < 2; l++) begin
        // Lanes come up one per cycle, so arrival spread stays within one LMFC.
        if (link_up[l]) begin
          lane_arrived[l*N_LANES +: N_LANES] <= {lane_arrived[l*N_LANES +: N_LANES-1], 1'b1};
        end else begin
          lane_arrived[l*N_LANES +: N_LANES] <= '0;
        end
      end
      ilas_to_data <= send_ilas & link_up;
    end
  end
endmodule
